// File: scc_consts.vh
// constants for the stepper current control block
`ifndef SCC_CONSTS_VH
`define SCC_CONSTS_VH

// clock
`define SCC_CLK_HZ          54'd50000000
`define SCC_CLK_KHZ         32'd50000

// register byte offsets
`define SCC_OFF_CTRL        8'h00
`define SCC_OFF_ODFREQ      8'h04
`define SCC_OFF_CURRENT     8'h08
`define SCC_OFF_STATUS      8'h0c
`define SCC_OFF_POSITION    8'h10

// control register fields
`define SCC_CTRL_BUSMODE    0
`define SCC_CTRL_ODEN       1
`define SCC_CTRL_CSEN       2
`define SCC_CTRL_DLY_LO     4
`define SCC_CTRL_DLY_HI     7
`define SCC_CTRL_RES_LO     8
`define SCC_CTRL_RES_HI     11

// status register fields
`define SCC_STAT_OD         0
`define SCC_STAT_STOP       1
`define SCC_STAT_CS         2

// reset values
`define SCC_CTRL_RST        12'h002
`define SCC_ODFREQ_RST      18'h003e8
`define SCC_RUN_RST         8'h10
`define SCC_STOP_RST        8'h08

// timing
`define SCC_ROTARY_DLY_MS   10'd40
`define SCC_DLY_SEL_MAX     4'he

// overdrive: release at 9/10 of engage, raise by 1/5
`define SCC_HYST_NUM        58'd9
`define SCC_HYST_DEN        58'd10
`define SCC_OD_DIV          9'd5

// axi responses
`define SCC_RESP_OKAY       2'h0
`define SCC_RESP_SLVERR     2'h2

`endif

// File: scc_current_ctrl.v
// stepper phase-current selection with axi4-lite register access
// Behaviour
// R1: overdrive engages above switch rate, releases below, both scaled by microstep factor.
// R2: release threshold sits ten percent below the engage threshold.
// R3: engaged overdrive raises the commanded run current by about twenty percent.
// R4: after pulses stop, wait the current delay, then switch run to stop current.
// R5: rotary switch mode uses a fixed forty millisecond current delay.
// R6: bus mode delay is programmable, 1 to 1000 ms, in 15 settings.
// R7: stop reduction keeps the ratio between both phase currents unchanged.
// R8: reduction reaches both phases at the same clock edge.
// R9: each rising edge of the control pulse advances the motor one step.
// R10: current shaping applies only in bus mode with its enable set.
// R11: every pulse restarts the delay timer and restores run current at once.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scc_consts.vh"

module scc_current_ctrl #(
  parameter [31:0] MS_CYCLES = `SCC_CLK_KHZ
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        stepPulse,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [8:0]  phaseAmpA,
  output reg  [8:0]  phaseAmpB,
  output reg         phaseSignA,
  output reg         phaseSignB,
  output reg         stepAdvance,
  output reg         overdriveOn,
  output reg         stopCurrentOn,
  output reg         csActive
);

  // microstep factor per resolution code
  function [9:0] resFactor;
    input [3:0] code;
    begin
      case (code)
        4'h0:    resFactor = 10'd1;
        4'h1:    resFactor = 10'd2;
        4'h2:    resFactor = 10'd4;
        4'h3:    resFactor = 10'd5;
        4'h4:    resFactor = 10'd8;
        4'h5:    resFactor = 10'd10;
        4'h6:    resFactor = 10'd16;
        4'h7:    resFactor = 10'd20;
        4'h8:    resFactor = 10'd32;
        4'h9:    resFactor = 10'd64;
        4'ha:    resFactor = 10'd128;
        4'hb:    resFactor = 10'd256;
        default: resFactor = 10'd512;
      endcase
    end
  endfunction

  // fifteen delay settings in ms
  function [9:0] delayMs;
    input [3:0] sel;
    begin
      case (sel)
        4'h0:    delayMs = 10'd1;
        4'h1:    delayMs = 10'd2;
        4'h2:    delayMs = 10'd3;
        4'h3:    delayMs = 10'd5;
        4'h4:    delayMs = 10'd8;
        4'h5:    delayMs = 10'd10;
        4'h6:    delayMs = 10'd15;
        4'h7:    delayMs = 10'd20;
        4'h8:    delayMs = 10'd30;
        4'h9:    delayMs = 10'd40;
        4'ha:    delayMs = 10'd60;
        4'hb:    delayMs = 10'd100;
        4'hc:    delayMs = 10'd200;
        4'hd:    delayMs = 10'd500;
        default: delayMs = 10'd1000;
      endcase
    end
  endfunction

  // registers
  reg  [11:0] ctrl_q;
  reg  [17:0] odFreq_q;
  reg  [7:0]  runCur_q;
  reg  [7:0]  stopCur_q;
  reg  [7:0]  awAddr_q;
  reg         awHeld_q;
  reg  [31:0] wData_q;
  reg  [3:0]  wStrb_q;
  reg         wHeld_q;

  // step tracking
  reg         stepPrev_q;
  reg         seenEdge_q;
  reg  [25:0] intv_q;
  reg  [25:0] dly_q;
  reg  [9:0]  micro_q;
  reg  [1:0]  fullIdx_q;
  reg  [15:0] stepCount_q;

  wire        busMode  = ctrl_q[`SCC_CTRL_BUSMODE];
  wire        odEnable = ~busMode | ctrl_q[`SCC_CTRL_ODEN];
  wire [3:0]  dlySel   = ctrl_q[`SCC_CTRL_DLY_HI:`SCC_CTRL_DLY_LO];
  wire [9:0]  factor   = resFactor(ctrl_q[`SCC_CTRL_RES_HI:`SCC_CTRL_RES_LO]);
  wire        stepEdge = stepPulse & ~stepPrev_q; // [R9]

  // engage rate = switch frequency times microstep factor
  wire [27:0] fOn     = {10'h0, odFreq_q} * {18'h0, factor}; // [R1]
  wire [25:0] period  = (intv_q == 26'h3ffffff) ? intv_q : intv_q + 26'd1;
  wire [53:0] prod    = {28'h0, period} * {26'h0, fOn};
  // rate above fOn means period * fOn below the clock rate
  wire        fastOn  = prod < `SCC_CLK_HZ; // [R1]
  // release when rate < 0.9 fOn, i.e. 10 * clk < 9 * period * fOn
  wire        slowOff = ({4'h0, prod} * `SCC_HYST_NUM) >
                        ({4'h0, `SCC_CLK_HZ} * `SCC_HYST_DEN); // [R2]

  wire [9:0]  msSel    = busMode ? delayMs(dlySel) : `SCC_ROTARY_DLY_MS; // [R5] [R6]
  wire [31:0] dlyLimit = msSel * MS_CYCLES;
  wire        dlyDone  = {6'h0, dly_q} >= dlyLimit - 32'd1;

  // overdrive adds one fifth of the run current
  wire [8:0]  runAmp = {1'b0, runCur_q} + ({1'b0, runCur_q} / `SCC_OD_DIV); // [R3]

  wire        awFire = s_axi_awvalid & s_axi_awready;
  wire        wFire  = s_axi_wvalid & s_axi_wready;
  wire        doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;

  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      laneMerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          laneMerge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  wire [31:0] ctrlMrg = laneMerge({20'h0, ctrl_q}, wData_q, wStrb_q);
  wire [31:0] odMrg   = laneMerge({14'h0, odFreq_q}, wData_q, wStrb_q);
  wire [31:0] curMrg  = laneMerge({16'h0, stopCur_q, runCur_q}, wData_q, wStrb_q);

  // write channel
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SCC_RESP_OKAY;
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awAddr_q      <= 8'h00;
      wData_q       <= 32'h0;
      wStrb_q       <= 4'h0;
      ctrl_q        <= `SCC_CTRL_RST;
      odFreq_q      <= `SCC_ODFREQ_RST;
      runCur_q      <= `SCC_RUN_RST;
      stopCur_q     <= `SCC_STOP_RST;
    end else begin
      if (awFire) begin
        awAddr_q      <= s_axi_awaddr;
        awHeld_q      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (wFire) begin
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
        wHeld_q      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SCC_RESP_OKAY;
        if (awAddr_q == `SCC_OFF_CTRL) begin
          ctrl_q <= ctrlMrg[11:0];
          // out-of-range delay codes clamp to the longest setting
          if (ctrlMrg[`SCC_CTRL_DLY_HI:`SCC_CTRL_DLY_LO] > `SCC_DLY_SEL_MAX) begin
            ctrl_q[`SCC_CTRL_DLY_HI:`SCC_CTRL_DLY_LO] <= `SCC_DLY_SEL_MAX; // [R6]
          end
        end else if (awAddr_q == `SCC_OFF_ODFREQ) begin
          odFreq_q <= odMrg[17:0];
        end else if (awAddr_q == `SCC_OFF_CURRENT) begin
          runCur_q  <= curMrg[7:0];
          stopCur_q <= curMrg[15:8];
        end else if (awAddr_q == `SCC_OFF_STATUS || awAddr_q == `SCC_OFF_POSITION) begin
          s_axi_bresp <= `SCC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `SCC_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel, one word answered the edge after the address
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `SCC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `SCC_RESP_OKAY;
        if (s_axi_araddr == `SCC_OFF_CTRL) begin
          s_axi_rdata <= {20'h0, ctrl_q};
        end else if (s_axi_araddr == `SCC_OFF_ODFREQ) begin
          s_axi_rdata <= {14'h0, odFreq_q};
        end else if (s_axi_araddr == `SCC_OFF_CURRENT) begin
          s_axi_rdata <= {16'h0, stopCur_q, runCur_q};
        end else if (s_axi_araddr == `SCC_OFF_STATUS) begin
          s_axi_rdata <= {29'h0, csActive, stopCurrentOn, overdriveOn};
        end else if (s_axi_araddr == `SCC_OFF_POSITION) begin
          s_axi_rdata <= {stepCount_q, 4'h0, fullIdx_q, micro_q};
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `SCC_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // step position and pulse interval
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      stepPrev_q  <= 1'b0;
      seenEdge_q  <= 1'b0;
      intv_q      <= 26'h0;
      micro_q     <= 10'h0;
      fullIdx_q   <= 2'h0;
      stepCount_q <= 16'h0;
      stepAdvance <= 1'b0;
    end else begin
      stepPrev_q  <= stepPulse;
      stepAdvance <= stepEdge; // [R9]
      if (stepEdge) begin
        seenEdge_q  <= 1'b1;
        intv_q      <= 26'h0;
        stepCount_q <= stepCount_q + 16'd1;
        if (micro_q >= factor - 10'd1) begin
          micro_q   <= 10'h0;
          fullIdx_q <= fullIdx_q + 2'd1; // [R9]
        end else begin
          micro_q <= micro_q + 10'd1;
        end
      end else if (intv_q != 26'h3ffffff) begin
        intv_q <= intv_q + 26'd1;
      end
    end
  end

  // overdrive with hysteresis; a slow running interval releases it too
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      overdriveOn <= 1'b0;
    end else if (!odEnable || !seenEdge_q) begin
      overdriveOn <= 1'b0;
    end else if (stepEdge && fastOn) begin
      overdriveOn <= 1'b1; // [R1]
    end else if (slowOff) begin
      overdriveOn <= 1'b0; // [R2]
    end
  end

  // current delay timer; reset starts in stop current since no pulse yet
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      dly_q         <= 26'h0;
      stopCurrentOn <= 1'b1;
    end else if (stepEdge) begin
      dly_q         <= 26'h0; // [R11]
      stopCurrentOn <= 1'b0; // [R11]
    end else if (!stopCurrentOn) begin
      if (dlyDone) begin
        stopCurrentOn <= 1'b1; // [R4]
      end else begin
        dly_q <= dly_q + 26'd1; // [R4]
      end
    end
  end

  // one amplitude feeds both phases on the same edge, so the ratio holds
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      phaseAmpA  <= 9'h0;
      phaseAmpB  <= 9'h0;
      phaseSignA <= 1'b0;
      phaseSignB <= 1'b0;
      csActive   <= 1'b0;
    end else begin
      if (stopCurrentOn) begin
        phaseAmpA <= {1'b0, stopCur_q}; // [R7] [R8]
        phaseAmpB <= {1'b0, stopCur_q}; // [R7] [R8]
      end else if (overdriveOn) begin
        phaseAmpA <= runAmp; // [R3]
        phaseAmpB <= runAmp; // [R3]
      end else begin
        phaseAmpA <= {1'b0, runCur_q};
        phaseAmpB <= {1'b0, runCur_q};
      end
      phaseSignA <= fullIdx_q[1];
      phaseSignB <= fullIdx_q[1] ^ fullIdx_q[0];
      csActive   <= busMode & ctrl_q[`SCC_CTRL_CSEN]; // [R10]
    end
  end

endmodule // scc_current_ctrl
`default_nettype wire

// File: scc_current_ctrl_props.sv
// assertions for the stepper current control block
`timescale 1ns/1ps
`default_nettype none
module scc_current_ctrl_props (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       stepPulse,
  input wire logic [8:0] phaseAmpA,
  input wire logic [8:0] phaseAmpB,
  input wire logic       phaseSignA,
  input wire logic       phaseSignB,
  input wire logic       stepAdvance,
  input wire logic       overdriveOn,
  input wire logic       stopCurrentOn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence newEdge; $rose(stepPulse); endsequence
  // shortest delay is 1 ms, so run current holds well past 8 cycles
  sequence stayRun; !stopCurrentOn [*8]; endsequence
  a_amp_equal: assert property (phaseAmpA == phaseAmpB)
    else $error("phase amplitudes differ");
  a_step_pulse: assert property (newEdge |=> stepAdvance)
    else $error("edge gave no step");
  a_step_cause: assert property (stepAdvance |-> $past(stepPulse) && !$past(stepPulse, 2))
    else $error("step without edge");
  a_run_hold: assert property (stepAdvance |-> stayRun)
    else $error("stop current too early");
  a_stop_leave: assert property ($fell(stopCurrentOn) |-> stepAdvance)
    else $error("stop left without step");
  a_amp_drop: assert property ($rose(stopCurrentOn) |=> phaseAmpA != $past(phaseAmpA))
    else $error("amplitude not reduced");
  a_od_cause: assert property ($rose(overdriveOn) |-> $past(stepPulse) || $past(stepPulse, 2))
    else $error("overdrive without edge");
  a_sign_step: assert property (!$stable({phaseSignA, phaseSignB}) |-> $past(stepAdvance))
    else $error("sign moved without step");
endmodule // scc_current_ctrl_props
bind scc_current_ctrl scc_current_ctrl_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .stepPulse(stepPulse), .phaseAmpA(phaseAmpA), .phaseAmpB(phaseAmpB), .phaseSignA(phaseSignA),
  .phaseSignB(phaseSignB), .stepAdvance(stepAdvance), .overdriveOn(overdriveOn),
  .stopCurrentOn(stopCurrentOn));
`default_nettype wire

// File: scc_current_ctrl_test.sv
// self-checking bench for the stepper current control block
`timescale 1ns/1ps
`default_nettype none
module scc_current_ctrl_test;
  logic        sys_clk = 1'b0, rst_n = 1'b0, go = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] period = 16'h2, count = 16'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0, run;
  logic [31:0] wdata = 32'h0;
  logic [33:0] e;
  logic [33:0] expq[$];
  wire logic   awready, wready, bvalid, arready, rvalid, stepPulse, busy, adv, odOn, stopOn, csOn;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [8:0]  ampA, ampB;
  wire logic        signA, signB;
  int err_count = 0, checks_done = 0, steps = 0, advCount = 0;
  always #10 sys_clk = ~sys_clk;
  scc_current_ctrl #(.MS_CYCLES(32'd10)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .stepPulse(stepPulse), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phaseAmpA(ampA), .phaseAmpB(ampB), .phaseSignA(signA), .phaseSignB(signB),
    .stepAdvance(adv), .overdriveOn(odOn), .stopCurrentOn(stopOn), .csActive(csOn));
  scc_step_src src (.sys_clk(sys_clk), .rst_n(rst_n), .period(period), .count(count),
    .go(go), .stepPulse(stepPulse), .busy(busy));
  task automatic chk(input logic ok, input string m);
    checks_done++;
    // an unknown flag must count as a mismatch, not slip through
    if (ok !== 1'b1) begin
      err_count++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    expq.push_back({r, 32'h0});
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    expq.push_back(x);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic pulses(input logic [15:0] p, input logic [15:0] n);
    @(posedge sys_clk);
    period <= p;
    count <= n;
    go <= 1'b1;
    steps += n;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    while (busy) @(posedge sys_clk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (rst_n && adv) advCount++;
    if (rst_n && ((bvalid && bready) || (rvalid && rready))) begin
      e = (expq.size() != 0) ? expq.pop_front() : 34'h3ffffffff;
      chk((bvalid ? {bresp, 32'h0} : {rresp, rdata}) === e, "bus result");
    end
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    $display("Error %0t: timeout", $time);
    results();
  end
  initial begin
    void'($urandom(32'h33450d24));
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h00, {2'h0, 32'h002});
    rd(8'h04, {2'h0, 32'h3e8});
    rd(8'h0c, {2'h0, 32'h002});
    rd(8'h20, {2'h2, 32'h0});
    wr(8'h24, 32'h1, 2'h2);
    $display("test 1 done");
    wr(8'h00, 32'h004, 2'h0);
    pulses(16'd50, 16'd1);
    // level flags follow one edge after the pulse is seen, amplitudes one edge later
    repeat (2) @(posedge sys_clk);
    chk(csOn === 1'b0 && stopOn === 1'b0 && ampA === 9'h010, "rotary run");
    chk(ampB === ampA && signA === 1'b0 && signB === 1'b1, "both phases");
    // 40 ms at 10 cycles per ms is 400 cycles after the pulse edge
    repeat (394) @(posedge sys_clk);
    chk(stopOn === 1'b0, "rotary delay short");
    repeat (6) @(posedge sys_clk);
    chk(stopOn === 1'b1 && ampA === 9'h008 && ampB === 9'h008, "rotary stop");
    rd(8'h10, {2'h0, 32'h00010400});
    $display("test 2 done");
    run = 8'h40 + 8'($urandom_range(63));
    wr(8'h08, {16'h0, 1'b0, run[7:1], run}, 2'h0);
    wr(8'h00, 32'h0f7, 2'h0);
    rd(8'h00, {2'h0, 32'h0e7});
    chk(csOn === 1'b1, "shaping on");
    wr(8'h04, 32'h3d090, 2'h0);
    pulses(16'd180, 16'd4);
    repeat (3) @(posedge sys_clk);
    chk(odOn === 1'b1 && ampA === {1'b0, run} + 9'(run / 8'd5), "overdrive on");
    pulses(16'd210, 16'd3);
    chk(odOn === 1'b1, "hysteresis hold");
    pulses(16'd240, 16'd2);
    repeat (3) @(posedge sys_clk);
    chk(odOn === 1'b0 && ampA === {1'b0, run}, "overdrive off");
    $display("test 3 done");
    wr(8'h00, 32'h107, 2'h0);
    pulses(16'd180, 16'd3);
    chk(odOn === 1'b0, "scaled no engage");
    // long gap first, so only the 90 cycle spacing can engage
    repeat (150) @(posedge sys_clk);
    pulses(16'd90, 16'd3);
    repeat (4) @(posedge sys_clk);
    chk(odOn === 1'b1 && stopOn === 1'b0, "scaled engage");
    repeat (10) @(posedge sys_clk);
    chk(stopOn === 1'b1 && ampA === {2'b0, run[7:1]}, "bus stop");
    chk(advCount == steps, "step count");
    $display("test 4 done");
    results();
  end
endmodule // scc_current_ctrl_test
`default_nettype wire

// File: scc_step_src.sv
// step pulse source standing in for the motion controller
`timescale 1ns/1ps
`default_nettype none
module scc_step_src (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] period,
  input  wire logic [15:0] count,
  input  wire logic        go,
  output var  logic        stepPulse,
  output wire logic        busy
);
  logic [15:0] tick_q;
  logic [15:0] left_q;
  // busy drops with the last pulse, so the bench sees the trailing gap
  always @(posedge sys_clk) begin
    if (!rst_n || go) begin
      left_q <= go ? count : 16'h0;
      tick_q <= 16'h0;
      stepPulse <= 1'b0;
    end else begin
      stepPulse <= (left_q != 16'h0) && (tick_q == 16'h0);
      if (left_q != 16'h0 && tick_q == 16'h0) left_q <= left_q - 16'h1;
      tick_q <= (tick_q == period - 16'h1) ? 16'h0 : tick_q + 16'h1;
    end
  end
  assign busy = left_q != 16'h0;
endmodule // scc_step_src
`default_nettype wire
